//--- core/frwc_defines.svh
// Constants for the flash read wait control block.
`ifndef FRWC_DEFINES_SVH
`define FRWC_DEFINES_SVH

`define FRWC_CLK_MHZ        100
`define FRWC_WAIT_W         2
`define FRWC_WAIT_ZERO      2'h0
`define FRWC_WAIT_ONE       2'h1
`define FRWC_ADDR_W         24
`define FRWC_DATA_W         16
`define FRWC_PROG_MAX_MS    5
`define FRWC_ERASE_MAX_MS   500
`define FRWC_PROG_TYP_MS    2
`define FRWC_ERASE_TYP_MS   200
`define FRWC_PROG_CYC       (`FRWC_PROG_MAX_MS * 1000 * `FRWC_CLK_MHZ)
`define FRWC_ERASE_CYC      (`FRWC_ERASE_MAX_MS * 1000 * `FRWC_CLK_MHZ)
`define FRWC_PROG_TYP_CYC   (`FRWC_PROG_TYP_MS * 1000 * `FRWC_CLK_MHZ)
`define FRWC_ERASE_TYP_CYC  (`FRWC_ERASE_TYP_MS * 1000 * `FRWC_CLK_MHZ)
`define FRWC_TIMER_W        26

`endif

//--- core/frwc_pkg.sv
// Types for the flash read wait control block.
package frwc_pkg;
	typedef enum logic [1:0] {
		FRWC_IDLE,
		FRWC_READ,
		FRWC_PROG,
		FRWC_ERASE
	} frwc_state_t;
endpackage : frwc_pkg

//--- core/frwc_busy_timer.sv
// Down counter that times one program or erase operation.
`include "frwc_defines.svh"
module frwc_busy_timer #(
	parameter int TW = `FRWC_TIMER_W
) (
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire logic          load,
	input  wire logic [TW-1:0] loadValue,
	output logic               done
);
	logic [TW-1:0] count_r;
	logic [TW-1:0] count_nxt;
	logic          run_r;
	logic          run_nxt;
	logic          done_r;
	logic          done_nxt;

	always_comb begin
		count_nxt = count_r;
		run_nxt   = run_r;
		done_nxt  = 1'b0;
		if (load) begin
			count_nxt = loadValue;
			run_nxt   = 1'b1;
		end else if (run_r) begin
			if (count_r <= TW'(1)) begin
				run_nxt  = 1'b0;
				done_nxt = 1'b1;
			end else begin
				count_nxt = count_r - TW'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			count_r <= '0;
			run_r   <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			count_r <= count_nxt;
			run_r   <= run_nxt;
			done_r  <= done_nxt;
		end
	end

	assign done = done_r;
endmodule : frwc_busy_timer

//--- core/flash_read_wait_control.sv
// Flash read access sequencer with waitstates and program/erase timing.
`include "frwc_defines.svh"
module flash_read_wait_control
	import frwc_pkg::*;
#(
	parameter int AW        = `FRWC_ADDR_W,
	parameter int DW        = `FRWC_DATA_W,
	parameter int PROG_CYC  = `FRWC_PROG_TYP_CYC,
	parameter int ERASE_CYC = `FRWC_ERASE_TYP_CYC
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	input  wire logic [`FRWC_WAIT_W-1:0] flashWaitCount,
	input  wire logic                   readReq,
	input  wire logic                   readSeq,
	input  wire logic [AW-1:0]          readAddr,
	input  wire logic                   progReq,
	input  wire logic                   eraseReq,
	input  wire logic [DW-1:0]          arrayData,
	output logic [AW-1:0]               arrayAddr,
	output logic                        arrayRead,
	output logic [DW-1:0]               readData,
	output logic                        readValid,
	output logic                        busy,
	output logic                        opDone,
	output logic                        waitCodeError
);
	// The timer width covers the longest erase count at the system clock.
	localparam int TW = `FRWC_TIMER_W;

	frwc_state_t               state_r;
	frwc_state_t               state_nxt;
	logic [`FRWC_WAIT_W-1:0]   waitLeft_r;
	logic [`FRWC_WAIT_W-1:0]   waitLeft_nxt;
	logic [`FRWC_WAIT_W-1:0]   waitSel;
	logic [AW-1:0]             arrayAddr_r;
	logic [AW-1:0]             arrayAddr_nxt;
	logic                      arrayRead_r;
	logic                      arrayRead_nxt;
	logic [DW-1:0]             readData_r;
	logic [DW-1:0]             readData_nxt;
	logic                      readValid_r;
	logic                      readValid_nxt;
	logic                      captureNow;
	logic                      busy_r;
	logic                      busy_nxt;
	logic                      opDone_r;
	logic                      opDone_nxt;
	logic                      waitErr_r;
	logic                      waitErr_nxt;
	logic                      timerLoad;
	logic [TW-1:0]             timerValue;
	logic                      timerDone;

	// Reserved codes fall back to one waitstate, the slower safe choice.
	function automatic logic [`FRWC_WAIT_W-1:0] decodeWait(input logic [`FRWC_WAIT_W-1:0] code);
		case (code)
			`FRWC_WAIT_ZERO: decodeWait = 2'h0;
			`FRWC_WAIT_ONE:  decodeWait = 2'h1;
			default:         decodeWait = 2'h1;
		endcase
	endfunction : decodeWait

	// Flags a code outside the two defined settings.
	function automatic logic isReservedWait(input logic [`FRWC_WAIT_W-1:0] code);
		case (code)
			`FRWC_WAIT_ZERO: isReservedWait = 1'b0;
			`FRWC_WAIT_ONE:  isReservedWait = 1'b0;
			default:         isReservedWait = 1'b1;
		endcase
	endfunction : isReservedWait

	assign waitSel = decodeWait(flashWaitCount);

	always_comb begin
		state_nxt     = state_r;
		waitLeft_nxt  = waitLeft_r;
		arrayAddr_nxt = arrayAddr_r;
		arrayRead_nxt = 1'b0;
		timerLoad     = 1'b0;
		timerValue    = '0;

		// Program and erase win over a read raised in the same cycle.
		case (state_r)
			FRWC_IDLE: begin
				if (progReq) begin
					timerLoad  = 1'b1;
					timerValue = TW'(PROG_CYC);
					state_nxt  = FRWC_PROG;
				end else if (eraseReq) begin
					timerLoad  = 1'b1;
					timerValue = TW'(ERASE_CYC);
					state_nxt  = FRWC_ERASE;
				end else if (readReq) begin
					// The address is held after the access so the array sees no needless toggling.
					arrayAddr_nxt = readAddr;
					arrayRead_nxt = 1'b1;
					if (readSeq) begin
						waitLeft_nxt = 2'h0;
					end else begin
						waitLeft_nxt = waitSel;
					end
					state_nxt = FRWC_READ;
				end
			end
			FRWC_READ: begin
				if (waitLeft_r == 2'h0) begin
					state_nxt = FRWC_IDLE;
				end else begin
					// Each wait cycle keeps arrayRead up so the array sees a steady request.
					arrayRead_nxt = 1'b1;
					waitLeft_nxt  = waitLeft_r - 2'h1;
				end
			end
			// A read raised during program or erase is not queued; the master retries it.
			FRWC_PROG, FRWC_ERASE: begin
				if (timerDone) begin
					state_nxt = FRWC_IDLE;
				end
			end
			default: begin
				state_nxt = FRWC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_r     <= FRWC_IDLE;
			waitLeft_r  <= 2'h0;
			arrayAddr_r <= '0;
			arrayRead_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			waitLeft_r  <= waitLeft_nxt;
			arrayAddr_r <= arrayAddr_nxt;
			arrayRead_r <= arrayRead_nxt;
		end
	end

	// The array word is taken in the last access cycle, while arrayRead still stands.
	assign captureNow = (state_r == FRWC_READ) && (waitLeft_r == 2'h0);

	always_comb begin
		readData_nxt  = readData_r;
		readValid_nxt = 1'b0;
		if (captureNow) begin
			readData_nxt  = arrayData;
			readValid_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			readData_r  <= '0;
			readValid_r <= 1'b0;
		end else begin
			readData_r  <= readData_nxt;
			readValid_r <= readValid_nxt;
		end
	end

	// Status flags are registered too, so every output leaves a flop directly.
	always_comb begin
		// Busy is taken from the next state, so it matches the state in the same cycle; requests seen while it is high are dropped.
		busy_nxt    = (state_nxt != FRWC_IDLE);
		opDone_nxt  = 1'b0;
		if (((state_r == FRWC_PROG) || (state_r == FRWC_ERASE)) && timerDone) begin
			opDone_nxt = 1'b1;
		end
		// reserved codes
		// The flag is a level that follows the wait code one edge late.
		waitErr_nxt = isReservedWait(flashWaitCount);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			busy_r    <= 1'b0;
			opDone_r  <= 1'b0;
			waitErr_r <= 1'b0;
		end else begin
			busy_r    <= busy_nxt;
			opDone_r  <= opDone_nxt;
			waitErr_r <= waitErr_nxt;
		end
	end

	// One shared timer is enough, since program and erase never overlap.
	frwc_busy_timer #(
		.TW(TW)
	) u_timer (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.load      (timerLoad),
		.loadValue (timerValue),
		.done      (timerDone)
	);

	// Outputs are plain copies of registers, with no logic behind the pins.
	assign arrayAddr     = arrayAddr_r;
	assign arrayRead     = arrayRead_r;
	assign readData      = readData_r;
	assign readValid     = readValid_r;
	assign busy          = busy_r;
	assign opDone        = opDone_r;
	assign waitCodeError = waitErr_r;
endmodule : flash_read_wait_control

//--- dv/frwc_chk.sv
// Port assertions for the flash read wait control block.
module frwc_chk (
	input wire logic	clk_sys,
	input wire logic	rstn,
	input wire logic [1:0]	flashWaitCount,
	input wire logic	readReq,
	input wire logic	readSeq,
	input wire logic	progReq,
	input wire logic	eraseReq,
	input wire logic	arrayRead,
	input wire logic	readValid,
	input wire logic	busy,
	input wire logic	opDone,
	input wire logic	waitCodeError
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic tk;
	assign tk = !busy && readReq && !progReq && !eraseReq;
	property p_seq; tk && readSeq |=> arrayRead ##1 readValid && !busy; endproperty
	a_seq: assert property (p_seq) else $error("seq latency");
	property p_ws0; tk && !readSeq && flashWaitCount == 2'h0 |=> arrayRead ##1 readValid; endproperty
	a_ws0: assert property (p_ws0) else $error("ws0 latency");
	property p_ws1; tk && !readSeq && flashWaitCount != 2'h0 |=> arrayRead [*2] ##1 readValid;
	endproperty
	a_ws1: assert property (p_ws1) else $error("ws1 latency");
	property p_rsv; flashWaitCount[1] |=> waitCodeError; endproperty
	a_rsv: assert property (p_rsv) else $error("no code error");
	property p_cod; !flashWaitCount[1] |=> !waitCodeError; endproperty
	a_cod: assert property (p_cod) else $error("false code error");
	property p_vp; readValid |=> !readValid; endproperty
	a_vp: assert property (p_vp) else $error("valid too long");
	property p_op; opDone |-> !busy ##1 !opDone; endproperty
	a_op: assert property (p_op) else $error("done pulse");
	property p_ar; arrayRead |-> busy && !readValid; endproperty
	a_ar: assert property (p_ar) else $error("access phase");
	c_seq: cover property (tk && readSeq);
	c_ws1: cover property (tk && flashWaitCount == 2'h1);
	c_op: cover property (opDone);
endmodule : frwc_chk
bind flash_read_wait_control frwc_chk chk_u (
	.clk_sys        (clk_sys),
	.rstn           (rstn),
	.flashWaitCount (flashWaitCount),
	.readReq        (readReq),
	.readSeq        (readSeq),
	.progReq        (progReq),
	.eraseReq       (eraseReq),
	.arrayRead      (arrayRead),
	.readValid      (readValid),
	.busy           (busy),
	.opDone         (opDone),
	.waitCodeError  (waitCodeError)
);

//--- dv/frwc_array_model.sv
// Flash array model answering each address with a fixed pattern.
module frwc_array_model (
	input wire logic [23:0]	arrayAddr,
	input wire logic	arrayRead,
	output logic [15:0]	arrayData
);
	timeunit 1ns;
	timeprecision 1ps;
	// Outside an access the inverse shows, so stale capture cannot pass.
	assign arrayData = {16{!arrayRead}} ^ arrayAddr[15:0] ^ 16'h5a5a;
endmodule : frwc_array_model

//--- dv/flash_read_wait_control_bench.sv
// Bench for the flash read wait control block.
`define CHK(n, e, a) begin n_tests++; if ((e) !== (a)) begin err_count++; \
	$display("mismatch %s exp %0h got %0h", n, e, a); end end
module flash_read_wait_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rstn, readReq, readSeq, progReq, eraseReq, arrayRead, readValid, busy, opDone, wce;
	logic [1:0] wc;
	logic [23:0] ad, arrayAddr;
	logic [15:0] arrayData, readData;
	int err_count, n_tests, cyc, k;
	flash_read_wait_control #(.PROG_CYC(10), .ERASE_CYC(20)) dut_u (.clk_sys, .rstn,
		.flashWaitCount(wc), .readReq, .readSeq, .readAddr(ad), .progReq, .eraseReq,
		.arrayData, .arrayAddr, .arrayRead, .readData, .readValid, .busy, .opDone,
		.waitCodeError(wce));
	frwc_array_model mdl_u (.arrayAddr, .arrayRead, .arrayData);
	// A bounded wait; running past the limit shows up as a latency mismatch.
	task automatic waitFor(input logic pickOp);
		k = 0;
		while ((pickOp ? opDone : readValid) !== 1'b1 && k < 40) begin
			@(negedge clk_sys);
			k++;
		end
	endtask : waitFor
	task automatic rd(input logic sq, input logic [1:0] w);
		readReq = 1'b1;
		readSeq = sq;
		wc = w;
		ad = ad + 24'h000101;
		@(negedge clk_sys);
		readReq = 1'b0;
		waitFor(1'b0);
		`CHK("latency", (sq || w == 2'h0) ? 1 : 2, k)
		`CHK("address", ad, arrayAddr)
		`CHK("data", ad[15:0] ^ 16'h5a5a, readData)
		`CHK("code error", w[1], wce)
		@(negedge clk_sys);
	endtask : rd
	task automatic op(input logic er);
		progReq = !er;
		eraseReq = er;
		readReq = 1'b1;
		@(negedge clk_sys);
		progReq = 1'b0;
		eraseReq = 1'b0;
		readReq = 1'b0;
		waitFor(1'b1);
		`CHK("op time", er ? 21 : 11, k)
		@(negedge clk_sys);
	endtask : op
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			results();
		end
	end
	// clock limit
	// The clock runs at the 100 MHz of FRWC_CLK_MHZ; PROG_CYC and ERASE_CYC shorten the run, and no check here depends on its period.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		{rstn, readReq, readSeq, progReq, eraseReq, wc, ad} = '0;
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		// waitstate choice
		// The array model answers at once, so every code is exercised, not only the two legal ones.
		for (int i = 0; i < 8; i++)
			rd(i[2], i[1:0]);
		$display("read test done");
		op(1'b0);
		op(1'b1);
		$display("program and erase test done");
		results();
	end
endmodule : flash_read_wait_control_bench
